/* src/pms_mgmt.sv */
// Serial management slave, strap latch, interrupt register and Wishbone status port
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pms_defines.svh"

module pms_mgmt #(
  parameter logic [15:0] ID1_VALUE = 16'h1234,  // Arbitrary identifier value
  parameter logic [15:0] ID2_VALUE = 16'h5678   // Arbitrary identifier value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [2:0]  device_address_strap_i,
  input  wire logic        autoneg_enable_strap_i,
  input  wire logic        mode_a_strap_i,
  input  wire logic [7:0]  cond_event_i,
  input  wire logic [15:0] phy_status_i,
  output logic [15:0]      ctrl_o,
  output logic             interrupt_output_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o
);

  pms_pkg::pms_regs_type q;
  pms_pkg::pms_regs_type d;

  logic [6:0]  sync_q;
  logic        mdc_s;
  logic        mdio_s;
  logic [2:0]  addr_s;
  logic        an_s;
  logic        iso_s;
  logic [4:0]  own_addr;
  logic        mdc_rise;
  logic [9:0]  addr_bits;
  logic        addr_hit;
  logic        int_clr;
  logic        int_pending;
  logic        wb_req;

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  pms_sync #(
    .W (7)
  ) u_sync (
    .clk_i (clk_i),
    .d_i   ({mdc_i, mdio_i, device_address_strap_i, autoneg_enable_strap_i, mode_a_strap_i}),
    .q_o   (sync_q)
  );

  assign mdc_s  = sync_q[6];
  assign mdio_s = sync_q[5];
  assign addr_s = sync_q[4:2];
  assign an_s   = sync_q[1];
  assign iso_s  = sync_q[0];

  // ***********************************************
  // Register read mux
  // ***********************************************
  function automatic logic [15:0] pms_read_reg(input logic [4:0] num, input pms_pkg::pms_regs_type r,
                                               input logic [15:0] stat);
    logic [15:0] v;
    v = 16'h0000;
    case (num)
      `PMS_REG_CTRL:  v = r.ctrl;
      `PMS_REG_STAT:  v = stat;
      `PMS_REG_ID1:   v = ID1_VALUE;
      `PMS_REG_ID2:   v = ID2_VALUE;
      `PMS_REG_ADV:   v = r.adv;
      `PMS_REG_INT:   v = {r.int_en, r.int_stat};
      `PMS_REG_CTRL2: v = r.ctrl2;
      default:        v = 16'h0000;
    endcase
    return v;
  endfunction

  assign own_addr    = {2'b00, q.strap_addr};
  assign mdc_rise    = mdc_s & ~q.mdc_prev;
  assign addr_bits   = {q.shift[8:0], mdio_s};
  assign addr_hit    = (addr_bits[9:5] == own_addr) || (addr_bits[9:5] == `PMS_BCAST_ADDR);
  assign int_pending = |(q.int_en & q.int_stat);
  assign wb_req      = wb_cyc_i & wb_stb_i & ~q.wb_ack;

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb
  begin
    d        = q;
    int_clr  = 1'b0;
    d.mdc_prev = mdc_s;
    d.wb_stat  = (wb_req && !wb_we_i && (wb_adr_i == `PMS_WB_STAT)) ? 3'b000 : q.wb_stat;  // Set wins

    if (mdc_rise)
    begin
      case (q.state)
        pms_pkg::PMS_PRE:
        begin
          if (mdio_s)
          begin
            if (q.pre_cnt != `PMS_PRE_ONES)
            begin
              d.pre_cnt = q.pre_cnt + 6'd1;
            end
          end
          else if (q.pre_cnt == `PMS_PRE_ONES)
          begin
            d.state = pms_pkg::PMS_START;
          end
          else
          begin
            d.pre_cnt = 6'd0;
          end
        end
        pms_pkg::PMS_START:
        begin
          d.pre_cnt = 6'd0;
          d.bit_cnt = 5'd0;
          d.state   = mdio_s ? pms_pkg::PMS_OPC : pms_pkg::PMS_PRE;
        end
        pms_pkg::PMS_OPC:
        begin
          d.shift   = {q.shift[14:0], mdio_s};
          d.bit_cnt = q.bit_cnt + 5'd1;
          if (q.bit_cnt == `PMS_OP_LAST)
          begin
            d.bit_cnt = 5'd0;
            d.is_read = ({q.shift[0], mdio_s} == `PMS_OP_READ);
            if (({q.shift[0], mdio_s} == `PMS_OP_READ) || ({q.shift[0], mdio_s} == `PMS_OP_WRITE))
            begin
              d.state = pms_pkg::PMS_ADDR;
            end
            else
            begin
              d.state = pms_pkg::PMS_PRE;
            end
          end
        end
        pms_pkg::PMS_ADDR:
        begin
          d.shift   = {q.shift[14:0], mdio_s};
          d.bit_cnt = q.bit_cnt + 5'd1;
          if (q.bit_cnt == `PMS_ADDR_LAST)
          begin
            d.bit_cnt = 5'd0;
            d.reg_num = addr_bits[4:0];
            if (!addr_hit)
            begin
              d.state = pms_pkg::PMS_IGN;
              d.wb_stat[`PMS_EV_IGNORE] = 1'b1;
            end
            else
            begin
              d.state = pms_pkg::PMS_TA;
              if (q.is_read)
              begin
                d.rd_data = pms_read_reg(addr_bits[4:0], q, phy_status_i);
                int_clr   = (addr_bits[4:0] == `PMS_REG_INT);
              end
            end
          end
        end
        pms_pkg::PMS_TA:
        begin
          // First turnaround bit stays released; drive starts after its edge
          d.bit_cnt = q.bit_cnt + 5'd1;
          if (q.is_read && (q.bit_cnt == 5'd0))
          begin
            d.mdio_oe = 1'b1;
            d.mdio_o  = 1'b0;
          end
          if (q.bit_cnt == `PMS_TA_LAST)
          begin
            d.bit_cnt = 5'd0;
            d.state   = pms_pkg::PMS_DATA;
            if (q.is_read)
            begin
              d.mdio_o  = q.rd_data[15];
              d.rd_data = {q.rd_data[14:0], 1'b0};
            end
          end
        end
        pms_pkg::PMS_DATA:
        begin
          d.bit_cnt = q.bit_cnt + 5'd1;
          d.shift   = {q.shift[14:0], mdio_s};
          if (q.is_read)
          begin
            d.mdio_o  = q.rd_data[15];
            d.rd_data = {q.rd_data[14:0], 1'b0};
          end
          if (q.bit_cnt == `PMS_DATA_LAST)
          begin
            d.bit_cnt = 5'd0;
            d.pre_cnt = 6'd0;
            d.state   = pms_pkg::PMS_PRE;
            d.mdio_oe = 1'b0;
            d.mdio_o  = 1'b0;
            if (q.is_read)
            begin
              d.wb_stat[`PMS_EV_READ] = 1'b1;
            end
            else
            begin
              d.wb_stat[`PMS_EV_WRITE] = 1'b1;
              case (q.reg_num)
                `PMS_REG_CTRL:  d.ctrl   = {q.shift[14:0], mdio_s};
                `PMS_REG_ADV:   d.adv    = {q.shift[14:0], mdio_s};
                `PMS_REG_INT:   d.int_en = q.shift[14:7];
                `PMS_REG_CTRL2: d.ctrl2  = {q.shift[14:0], mdio_s};
                default:        d.ctrl   = q.ctrl;
              endcase
            end
          end
        end
        pms_pkg::PMS_IGN:
        begin
          d.bit_cnt = q.bit_cnt + 5'd1;
          if (q.bit_cnt == `PMS_IGN_LAST)
          begin
            d.bit_cnt = 5'd0;
            d.pre_cnt = 6'd0;
            d.state   = pms_pkg::PMS_PRE;
          end
        end
        default:
        begin
          d.state   = pms_pkg::PMS_PRE;
          d.pre_cnt = 6'd0;
          d.mdio_oe = 1'b0;
        end
      endcase
    end

    // ***********************************************
    // Condition status and interrupt pin
    // ***********************************************
    // Set wins over the read clear so a condition in the clearing cycle survives
    d.int_stat = (int_clr ? 8'h00 : q.int_stat) | cond_event_i;
    d.int_out  = q.ctrl2[`PMS_POL_BIT] ? int_pending : ~int_pending;

    // ***********************************************
    // Wishbone slave
    // ***********************************************
    d.wb_ack = wb_req;
    if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `PMS_WB_MASK))
    begin
      d.wb_mask = wb_dat_i[2:0];
    end
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        `PMS_WB_STAT:    d.wb_dat = {29'h0, q.wb_stat};
        `PMS_WB_MASK:    d.wb_dat = {29'h0, q.wb_mask};
        `PMS_WB_INFO:    d.wb_dat = {25'h0, q.strap_iso, q.strap_an, own_addr};
        `PMS_WB_INTVIEW: d.wb_dat = {16'h0, q.int_en, q.int_stat};
        default:         d.wb_dat = 32'h0000_0000;
      endcase
    end
    d.irq = |(q.wb_stat & q.wb_mask);

    // ***********************************************
    // Reset and strap capture
    // ***********************************************
    if (rst_i)
    begin
      d            = '0;
      d.state      = pms_pkg::PMS_PRE;
      d.mdc_prev   = mdc_s;
      d.strap_addr = (addr_s == 3'h0) ? `PMS_ADDR_DEFAULT : addr_s;
      d.strap_an   = an_s;
      d.strap_iso  = iso_s;
      d.ctrl[`PMS_CTRL_AN_BIT]  = an_s;
      d.ctrl[`PMS_CTRL_ISO_BIT] = iso_s;
      d.adv        = `PMS_ADV_RST;
      d.int_out    = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign mdio_o             = q.mdio_o;
  assign mdio_oe_o          = q.mdio_oe;
  assign ctrl_o             = q.ctrl;
  assign interrupt_output_o = q.int_out;
  assign wb_dat_o           = q.wb_dat;
  assign wb_ack_o           = q.wb_ack;
  assign irq_o              = q.irq;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  strap_hold_a: assert property (!$past(rst_i) |-> $stable({q.strap_addr, q.strap_an, q.strap_iso}))
    else $error("strap latch changed outside reset");

  autoneg_copy_a: assert property ($fell(rst_i) |-> (q.ctrl[`PMS_CTRL_AN_BIT] == q.strap_an))
    else $error("auto-negotiation strap not in control bit 12");

  addr_range_a: assert property ((own_addr[4:3] == 2'b00) && (own_addr != 5'h00))
    else $error("own address outside 1 to 7");

  ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o && (q.state == pms_pkg::PMS_TA))
    else $error("second turnaround bit not driven low");

  read_release_a: assert property ($fell(mdio_oe_o) |-> (q.state == pms_pkg::PMS_PRE) && q.is_read)
    else $error("line released at wrong point of read");

  ignore_quiet_a: assert property ((q.state == pms_pkg::PMS_IGN) |-> !mdio_oe_o)
    else $error("line driven during foreign frame");

  enable_gate_a: assert property ((!int_pending)[*2] |->
                                  (interrupt_output_o != $past(q.ctrl2[`PMS_POL_BIT])))
    else $error("interrupt asserted without enabled condition");

  event_set_a: assert property (((cond_event_i & q.int_en) != 8'h00) |=> ##1
                                (interrupt_output_o == q.ctrl2[`PMS_POL_BIT]) || $changed(q.ctrl2))
    else $error("enabled condition did not raise interrupt");

  read_clear_a: assert property (int_clr && (cond_event_i == 8'h00) |=> (q.int_stat == 8'h00))
    else $error("status not cleared by read");

  polarity_rst_a: assert property ($fell(rst_i) |-> !q.ctrl2[`PMS_POL_BIT] && interrupt_output_o)
    else $error("interrupt not active low after reset");

  wb_answer_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

endmodule
`default_nettype wire

/* src/pms_defines.svh */
// Offsets, field positions, reset values and counts of the management block
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// Serial frame counts
`define PMS_PRE_ONES      6'd32
`define PMS_OP_LAST       5'd1
`define PMS_ADDR_LAST     5'd9
`define PMS_TA_LAST       5'd1
`define PMS_DATA_LAST     5'd15
`define PMS_IGN_LAST      5'd17
`define PMS_OP_READ       2'b10
`define PMS_OP_WRITE      2'b01

// Management register numbers
`define PMS_REG_CTRL      5'h00
`define PMS_REG_STAT      5'h01
`define PMS_REG_ID1       5'h02
`define PMS_REG_ID2       5'h03
`define PMS_REG_ADV       5'h04
`define PMS_REG_LPA       5'h05
`define PMS_REG_ANX       5'h06
`define PMS_REG_INT       5'h1B
`define PMS_REG_CTRL2     5'h1F

// Field positions
`define PMS_CTRL_AN_BIT   12
`define PMS_CTRL_ISO_BIT  10
`define PMS_POL_BIT       9

// Reset values
`define PMS_ADV_RST       16'h0001
`define PMS_ADDR_DEFAULT  3'h1
`define PMS_BCAST_ADDR    5'h00

// Wishbone word offsets
`define PMS_WB_STAT       8'h00
`define PMS_WB_MASK       8'h04
`define PMS_WB_INFO       8'h08
`define PMS_WB_INTVIEW    8'h0C

// Wishbone status bits
`define PMS_EV_READ       0
`define PMS_EV_WRITE      1
`define PMS_EV_IGNORE     2

`endif

/* src/pms_pkg.sv */
// Types of the serial management block
package pms_pkg;

  typedef enum logic [2:0]
  {
    PMS_PRE   = 3'b000,
    PMS_START = 3'b001,
    PMS_OPC   = 3'b011,
    PMS_ADDR  = 3'b010,
    PMS_TA    = 3'b110,
    PMS_DATA  = 3'b111,
    PMS_IGN   = 3'b101
  } pms_fsm_type;

  typedef struct packed
  {
    pms_fsm_type  state;
    logic         mdc_prev;
    logic [5:0]   pre_cnt;
    logic [4:0]   bit_cnt;
    logic [15:0]  shift;
    logic         is_read;
    logic [4:0]   reg_num;
    logic [15:0]  rd_data;
    logic         mdio_o;
    logic         mdio_oe;
    logic [2:0]   strap_addr;
    logic         strap_an;
    logic         strap_iso;
    logic [15:0]  ctrl;
    logic [15:0]  adv;
    logic [7:0]   int_en;
    logic [7:0]   int_stat;
    logic [15:0]  ctrl2;
    logic         int_out;
    logic         wb_ack;
    logic [31:0]  wb_dat;
    logic [2:0]   wb_stat;
    logic [2:0]   wb_mask;
    logic         irq;
  } pms_regs_type;

endpackage

/* src/pms_sync.sv */
// Two-flop synchroniser for pins that come from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module pms_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pms_sync_type;

  pms_sync_type q;
  pms_sync_type d;

  // No reset: straps must keep flowing through while the chip is held in reset
  always_comb
  begin
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  assign q_o = q.s2;

endmodule
`default_nettype wire

/* tb/pms_host_model.sv */
// Station management host model that clocks frames onto the serial link
`timescale 1ns/10ps
`default_nettype none

module pms_host_model (
  input  wire logic clk_i,
  input  wire logic mdio_i,
  output var logic  mdc_o,
  output var logic  mdio_o,
  output var logic  mdio_oe_o
);
  // Half of the 80 ns management clock period at the 4 ns system clock
  localparam int HALF = 10;

  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
  end

  // Data moves in the low half so it is settled at the rising edge
  task automatic slot(input logic drv, input logic val, output logic seen);
    mdc_o <= 1'b0;
    mdio_oe_o <= drv;
    mdio_o <= val;
    repeat (HALF) @(posedge clk_i);
    seen = mdio_i;
    mdc_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask

  // Preamble, start, opcode and both addresses go out MSB first
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] ta);
    logic [45:0] hd;
    logic        wr;
    hd = {32'hFFFFFFFF, 2'h1, op, phy, rg};
    wr = (op == 2'h1);
    for (int i = 45; i >= 0; i--)
      slot(1'b1, hd[i], ta[0]);
    // A read leaves turnaround and data to the device
    slot(wr, 1'b1, ta[1]);
    slot(wr, 1'b0, ta[0]);
    for (int i = 15; i >= 0; i--)
      slot(wr, wd[i], rd[i]);
    // Clock stands still and the line is released between frames
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb/pms_mgmt_tb.sv */
// Self-checking bench of the serial management block against a behavioural model
`timescale 1ns/10ps
`default_nettype none

module pms_mgmt_tb;
  localparam logic [15:0] ID1 = 16'hA5C3;  // Arbitrary identifier value
  localparam logic [15:0] ID2 = 16'h3C5A;  // Arbitrary identifier value

  logic        clk_i;
  logic        rst_i;
  logic        mdc;
  logic        mdio;
  logic        h_mdio;
  logic        h_oe;
  logic        d_mdio;
  logic        d_oe;
  logic [2:0]  a_strap;
  logic        an_strap;
  logic        iso_strap;
  logic [7:0]  cond;
  logic [15:0] status;
  logic [15:0] ctrl;
  logic        intr;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic [31:0] w;
  logic [15:0] rd;
  logic [1:0]  ta;
  int          err_total;
  int          checks_done;
  int          cycles;
  int          seed;
  int          drove;
  int          own;
  int          wb_stat;
  int          wb_mask;
  int          ex [0:31];

  // Pull-up holds the line high while nobody drives it
  assign mdio = h_oe ? h_mdio : (d_oe ? d_mdio : 1'b1);

  pms_mgmt #(.ID1_VALUE(ID1), .ID2_VALUE(ID2)) pms_mgmt_i (
    .clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(d_mdio), .mdio_oe_o(d_oe),
    .device_address_strap_i(a_strap), .autoneg_enable_strap_i(an_strap), .mode_a_strap_i(iso_strap),
    .cond_event_i(cond), .phy_status_i(status), .ctrl_o(ctrl), .interrupt_output_o(intr),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));

  pms_host_model pms_host_model_i (
    .clk_i(clk_i), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(h_mdio), .mdio_oe_o(h_oe));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    chk_data(nm, {31'h0, e}, {31'h0, g});
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (d_oe === 1'b1)
      drove++;
    if (cycles == 90000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk_pin("bus answer drop", 1'b0, ack);
  endtask

  task automatic chk_int();
    logic act;
    act = ((ex[27] >> 8) & ex[27] & 'hFF) != 0;
    chk_pin("interrupt pin", !(act ^ ex[31][9]), intr);
  endtask

  task automatic mrd(input logic [4:0] p, input logic [4:0] r);
    logic hit;
    hit = (p == 5'h0 || p == own);
    drove = 0;
    pms_host_model_i.frame(2'h2, p, r, 16'h0, rd, ta);
    chk_data("turnaround", hit ? 2'h2 : 2'h3, ta);
    chk_data("read data", hit ? ex[r] : 16'hFFFF, rd);
    if (!hit)
      chk_data("foreign frame drive", 0, drove);
    if (hit && r == 5'h1B)
      ex[27] &= 'hFF00;
    wb_stat |= hit ? 1 : 4;
  endtask

  task automatic mwr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
    logic hit;
    hit = (p == 5'h0 || p == own);
    pms_host_model_i.frame(2'h1, p, r, d, rd, ta);
    if (hit && (r == 5'h0 || r == 5'h4 || r == 5'h1F))
      ex[r] = d;
    if (hit && r == 5'h1B)
      ex[27] = (d & 'hFF00) | (ex[27] & 'hFF);
    wb_stat |= hit ? 2 : 4;
  endtask

  task automatic ev(input logic [7:0] c);
    cond <= c;
    @(posedge clk_i);
    cond <= 8'h0;
    repeat (4) @(posedge clk_i);
    ex[27] |= c;
  endtask

  task automatic do_reset(input logic [2:0] a, input logic an, input logic iso);
    a_strap <= a;
    an_strap <= an;
    iso_strap <= iso;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    own = (a == 3'h0) ? 1 : a;
    for (int i = 0; i < 32; i++)
      ex[i] = 0;
    ex[0] = (an << 12) | (iso << 10);
    ex[1] = status;
    ex[2] = ID1;
    ex[3] = ID2;
    ex[4] = 1;
    wb_stat = 0;
    wb_mask = 0;
    @(posedge clk_i);
    // Straps move after release and must not be taken again
    a_strap <= ~a;
    an_strap <= ~an;
    iso_strap <= ~iso;
    @(posedge clk_i);
    chk_data("control pins", ex[0], ctrl);
    chk_pin("interrupt pin after reset", 1'b1, intr);
  endtask

  task automatic wb_status();
    wb(1'b0, 8'h00, 32'h0, w);
    chk_data("event status", wb_stat, w);
    wb_stat = 0;
    chk_pin("bus irq", 1'b0, irq);
  endtask

  initial
  begin
    seed = 84;
    {cyc, stb, we, adr, wdat, cond, status, sel} = '0;
    {a_strap, an_strap, iso_strap} = 5'h1F;
    rst_i = 1'b1;
    @(posedge clk_i);
    w = $random(seed);
    status <= w[15:0];
    do_reset(3'h5, 1'b0, 1'b1);
    wb(1'b0, 8'h08, 32'h0, w);
    chk_data("strap info", 32'h45, w);
    for (int r = 0; r < 8; r++)
      mrd(own[4:0], r[4:0]);
    mrd(5'h0, 5'h1);
    mrd(5'h6, 5'h1);
    mrd(5'h0D, 5'h1);
    // Bad opcode drops back to preamble search: no answer, no event
    pms_host_model_i.frame(2'h3, own[4:0], 5'h1, 16'h0, rd, ta);
    chk_data("bad opcode line", 16'hFFFF, rd);
    wb_status();
    wb(1'b1, 8'h04, 32'h4, w);
    wb_mask = 4;
    wb(1'b1, 8'h40, 32'h3, w);
    wb(1'b0, 8'h40, 32'h0, w);
    chk_data("unmapped read", 32'h0, w);
    wb(1'b0, 8'h04, 32'h0, w);
    chk_data("event mask", wb_mask, w);
    mrd(5'h2, 5'h1);
    chk_pin("bus irq", 1'b1, irq);
    wb_status();
    for (int i = 0; i < 3; i++)
    begin
      w = $random(seed);
      mwr(i == 1 ? 5'h0 : own[4:0], 5'h4, w[15:0]);
      mrd(own[4:0], 5'h4);
    end
    mwr(5'h3, 5'h4, 16'hBEEF);
    mrd(own[4:0], 5'h4);
    w = $random(seed);
    mwr(own[4:0], 5'h0, w[15:0]);
    chk_data("control pins", ex[0], ctrl);
    mwr(own[4:0], 5'h1B, 16'h01FF);
    ev(8'h02);
    chk_int();
    ev(8'h01);
    chk_int();
    wb(1'b0, 8'h0C, 32'h0, w);
    chk_data("interrupt view", ex[27], w);
    mrd(own[4:0], 5'h1B);
    chk_int();
    mrd(own[4:0], 5'h1B);
    mwr(own[4:0], 5'h1F, 16'h0200);
    chk_int();
    ev(8'h01);
    chk_int();
    for (int i = 0; i < 3; i++)
    begin
      w = $random(seed);
      mwr(own[4:0], 5'h1B, w[15:0]);
      ev(w[23:16]);
      chk_int();
      mrd(own[4:0], 5'h1B);
    end
    wb_status();
    do_reset(3'h0, 1'b1, 1'b0);
    mrd(5'h1, 5'h1);
    mrd(5'h0, 5'h0);
    end_sim();
  end
endmodule
`default_nettype wire
